// ==== e1_rx_error_status_counters_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module e1_rx_error_status_counters_bench
  import erc_pkg::*;
;
  localparam int TICK = 8;
  logic        core_clk;
  logic        rst;
  logic [3:0]  addr;
  logic        read_n;
  logic        write_n;
  logic        cs_n;
  logic        ack_n;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  erc_rx_evt_t ev;
  erc_cfg_t    cfg;
  logic        in_sync;
  logic        mf_sync;
  logic [5:0]  txv;
  logic        par_err;
  logic        lp;
  logic        ln;
  logic        req;
  logic        lerr;
  logic [7:0]  sn_out;
  logic        si13_out;
  logic        si15_out;
  logic [7:0]  sb [2];
  logic [31:0] seed;
  int          failures;
  int          num_checks;
  int          nf;
  int          nc;

  erc_status_counters #(.SIM_TICK_CYCLES(TICK)) u_erc_status_counters (
    .core_clk(core_clk), .rst(rst), .addr(addr), .read_n(read_n), .write_n(write_n),
    .chip_select_n(cs_n), .dma_acknowledge_n(ack_n), .wdata(wdata), .rdata(rdata),
    .rx_evt(ev), .cfg(cfg), .rx_in_sync(in_sync), .rx_mf_sync(mf_sync),
    .tx_mf_start(txv[0]), .tx_frame15(txv[1]), .tx_si13_wr(txv[2]),
    .tx_si15_wr(txv[3]), .tx_stack_slip(txv[4]), .parity_error_any(par_err),
    .tx_parity_input(txv[5]), .line_in_positive(lp), .line_in_negative(ln),
    .rx_transfer_request(req), .rx_line_error(lerr), .tx_sn_buffer(sn_out),
    .tx_si13(si13_out), .tx_si15(si15_out)
  );

  erc_host u_erc_host (
    .core_clk_rdata(rdata), .core_clk(core_clk), .addr(addr), .read_n(read_n),
    .write_n(write_n), .chip_select_n(cs_n), .dma_acknowledge_n(ack_n), .wdata(wdata)
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // saturating count, never wraps
  function automatic logic [9:0] sat(input int n, input int m);
    return (n > m) ? m[9:0] : n[9:0];
  endfunction : sat

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    logic [7:0] d;
    u_erc_host.rd(a, 1'b0, d);
    chk(n, e, d & m);
  endtask : rchk

  // errors while clear is held are dropped
  task automatic clr;
    @(posedge core_clk);
    cfg.clear_latches_control <= 1'b1;
    ev.fas_err <= 1'b1;
    cyc(3);
    cfg.clear_latches_control <= 1'b0;
    ev.fas_err <= 1'b0;
    cyc(2);
  endtask : clr

  task automatic results;
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  initial begin
    cyc(12000);
    failures++;
    results();
  end

  initial begin
    logic [7:0] d;
    logic [9:0] e;
    rst = 1'b1;
    ev = '0;
    cfg = '0;
    in_sync = 1'b1;
    mf_sync = 1'b1;
    txv = '0;
    par_err = 1'b0;
    lp = 1'b0;
    ln = 1'b0;
    seed = 32'hE80E4EC5;
    failures = 0;
    num_checks = 0;
    nf = 0;
    nc = 0;
    cyc(4);
    rst <= 1'b0;
    rchk("spare", ADDR_SPARE, 8'hFF, 8'h04);
    rchk("submf", ADDR_SUBMF, 8'hFF, 8'hC0);
    rchk("ext", ADDR_EXTEND, 8'hFF, EXT_ONES);
    rchk("unmapped", 4'hF, 8'hFF, 8'h00);
    for (int i = 0; i < 200; i++) begin
      @(posedge core_clk);
      seed = lfsr(seed);
      in_sync <= seed[0];
      ev.fas_err <= seed[1];
      ev.code_viol <= seed[2];
      txv <= {1'b0, seed[7:3]};
      mf_sync <= seed[9];
      nf += seed[1] & seed[0];
      nc += seed[2];
    end
    @(posedge core_clk);
    ev <= '0;
    txv <= '0;
    in_sync <= 1'b1;
    mf_sync <= 1'b1;
    cfg.optical_input_select <= 1'b1;
    @(posedge core_clk);
    ev.code_viol <= 1'b1;
    cyc(4);
    ev <= '0;
    cfg.optical_input_select <= 1'b0;
    rchk("framing", ADDR_FRAMING, 8'hFF, 8'(sat(nf, 255)));
    rchk("viol", ADDR_CODEVIOL, 8'hFF, 8'(sat(nc, 255)));
    clr();
    rchk("framing clr", ADDR_FRAMING, 8'hFF, 8'h00);
    cfg.code_violation_extension_enable <= 1'b1;
    nc = 0;
    for (int i = 0; i < 2; i++) begin
      ev.code_viol <= 1'b1;
      cyc(i ? 800 : 300);
      ev.code_viol <= 1'b0;
      nc += i ? 800 : 300;
      e = sat(nc, 1023);
      rchk("viol wide", ADDR_CODEVIOL, 8'hFF, e[7:0]);
      rchk("ext wide", ADDR_EXTEND, 8'hFF, EXT_ONES | {2'h0, e[9:8], 4'h0});
    end
    cfg.code_violation_extension_enable <= 1'b0;
    clr();
    cfg.alarm_sim <= 1'b1;
    ev.bit_strobe <= 1'b1;
    cyc(TICK * 260);
    cfg.alarm_sim <= 1'b0;
    ev.bit_strobe <= 1'b0;
    rchk("framing sim", ADDR_FRAMING, 8'hFF, 8'(sat(260, 255)));
    rchk("viol sim", ADDR_CODEVIOL, 8'hFF, 8'(sat(TICK * 65, 255)));
    rchk("parity sim", ADDR_SPARE, 8'h18, 8'h18);
    cfg.parity_clear_command <= 1'b1;
    cyc(2);
    cfg.parity_clear_command <= 1'b0;
    rchk("gpe clear", ADDR_SPARE, 8'h10, 8'h00);
    par_err <= 1'b1;
    cyc(1);
    par_err <= 1'b0;
    rchk("gpe set", ADDR_SPARE, 8'h10, 8'h10);
    cfg.crc_mode <= 1'b1;
    // skipped: out of sync, then doubleframe
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      ev.submf_end <= 1'b1;
      ev.submf_crc_err <= 1'b1;
      in_sync <= (i != 2);
      cfg.doubleframe_spare_select <= (i > 5);
    end
    @(posedge core_clk);
    ev <= '0;
    in_sync <= 1'b1;
    cfg <= '0;
    rchk("crc", ADDR_CRCERR, 8'hFF, 8'h05);
    lp <= 1'b1;
    ln <= 1'b1;
    cyc(3);
    chk("line", 8'h01, {7'h0, lerr});
    ln <= 1'b0;
    cyc(3);
    chk("line", 8'h00, {7'h0, lerr});
    cfg.signaling_stack_enable <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      seed = lfsr(seed);
      sb[i] = seed[7:0];
      ev.ts16_valid <= 1'b1;
      ev.ts16_byte <= seed[7:0];
    end
    @(posedge core_clk);
    ev <= '0;
    cyc(2);
    chk("request", 8'h01, {7'h0, req});
    rchk("stack first", ADDR_SIGSTACK, 8'hFF, sb[0]);
    chk("request", 8'h01, {7'h0, req});
    u_erc_host.rd(4'h0, 1'b1, d);
    chk("stack second", sb[1], d);
    cyc(1);
    chk("request", 8'h00, {7'h0, req});
    clr();
    cfg.crc_mode <= 1'b1;
    cfg.submultiframe_indication_enable <= 1'b1;
    u_erc_host.wr(ADDR_RXSNSTK, sb[0]);
    // frame 13 Si one, frame 15 Si zero twice, then multiframe start
    ev.word_valid <= 1'b1;
    ev.frame_num <= FRAME_13;
    ev.word <= 8'h80;
    ev.submf_end <= 1'b1;
    ev.submf_crc_err <= 1'b1;
    txv <= 6'h0C;
    cyc(1);
    ev.frame_num <= FRAME_15;
    ev.word <= 8'h7F;
    ev.submf_end <= 1'b0;
    cyc(1);
    ev.word <= 8'h15;
    cyc(1);
    ev.word_valid <= 1'b0;
    ev.mf_start <= 1'b1;
    txv[0] <= 1'b1;
    cyc(1);
    ev <= '0;
    txv[0] <= 1'b0;
    rchk("spare crc", ADDR_SPARE, 8'hC7, 8'hC6);
    rchk("service", ADDR_SERVICE, 8'hFF, 8'h95);
    rchk("submf crc", ADDR_SUBMF, 8'hC0, 8'h40);
    rchk("viol si", ADDR_CODEVIOL, 8'hFF, 8'h02);
    rchk("crc one", ADDR_CRCERR, 8'hFF, 8'h01);
    chk("tx stack", sb[0], sn_out);
    chk("tx si", 8'h03, {6'h0, si13_out, si15_out});
    u_erc_host.wr(ADDR_RXSNSTK, sb[1]);
    u_erc_host.rd(ADDR_RXSNSTK, 1'b0, d);
    rchk("flags clear", ADDR_SPARE, 8'hC0, 8'h00);
    cfg.auto_status_transmit <= 1'b1;
    mf_sync <= 1'b0;
    cyc(3);
    rchk("submf lost", ADDR_SUBMF, 8'hC0, 8'h00);
    chk("tx si auto", 8'h00, {6'h0, si13_out, si15_out});
    results();
  end
endmodule : e1_rx_error_status_counters_bench
`default_nettype wire

// ==== erc_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module erc_host (
  input  wire logic [7:0] core_clk_rdata,
  input  wire logic       core_clk,
  output logic      [3:0] addr,
  output logic            read_n,
  output logic            write_n,
  output logic            chip_select_n,
  output logic            dma_acknowledge_n,
  output logic      [7:0] wdata
);
  initial begin
    addr = 4'h0;
    read_n = 1'b1;
    write_n = 1'b1;
    chip_select_n = 1'b1;
    dma_acknowledge_n = 1'b1;
    wdata = 8'h00;
  end
  // polls well inside the flag interval
  // dma cycle needs no chip select
  task automatic rd(input logic [3:0] a, input logic dma, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    read_n <= 1'b0;
    chip_select_n <= dma;
    dma_acknowledge_n <= ~dma;
    repeat (2) @(posedge core_clk);
    d = core_clk_rdata;
    read_n <= 1'b1;
    chip_select_n <= 1'b1;
    dma_acknowledge_n <= 1'b1;
    // released lines never keep the old value
    addr <= ~a;
    wdata <= ~wdata;
  endtask : rd
  // one write access, sampled at the single edge it is held
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    write_n <= 1'b0;
    chip_select_n <= 1'b0;
    @(posedge core_clk);
    write_n <= 1'b1;
    chip_select_n <= 1'b1;
    addr <= ~a;
  endtask : wr
endmodule : erc_host
`default_nettype wire

// ==== erc_pkg.sv ====
package erc_pkg;
  // register addresses on the parallel port
  localparam logic [3:0] ADDR_FRAMING  = 4'h1;
  localparam logic [3:0] ADDR_CODEVIOL = 4'h2;
  localparam logic [3:0] ADDR_CRCERR   = 4'h3;
  localparam logic [3:0] ADDR_SERVICE  = 4'h4;
  localparam logic [3:0] ADDR_SPARE    = 4'h5;
  localparam logic [3:0] ADDR_SUBMF    = 4'h6;
  localparam logic [3:0] ADDR_SIGSTACK = 4'h7;
  localparam logic [3:0] ADDR_EXTEND   = 4'h9;
  localparam logic [3:0] ADDR_RXSNSTK  = 4'hB;
  // spare/flags register bit positions
  localparam int SP_TXFLG = 7;
  localparam int SP_RXFLG = 6;
  localparam int SP_SLIP  = 5;
  localparam int SP_GPE   = 4;
  localparam int SP_XPE   = 3;
  localparam int SP_RSIF  = 2;
  localparam int SP_RX_SI_FRAME13  = 1;
  localparam int SP_RX_SI_FRAME15  = 0;
  // submultiframe status bit positions
  localparam int SE_SI1 = 7;
  localparam int SE_SI2 = 6;
  localparam int SE_ERL = 0;
  // extension register: unused positions read one
  localparam logic [7:0] EXT_ONES = 8'hCC;
  localparam int EXT_CV8 = 4;
  localparam int EXT_CE8 = 0;
  localparam logic [9:0] MAX_NARROW = 10'h0FF;
  localparam logic [9:0] MAX_WIDE   = 10'h3FF;
  localparam logic [9:0] CNT_RESET  = 10'h000;
  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam logic [3:0] FRAME_13   = 4'hD;
  localparam logic [3:0] FRAME_15   = 4'hF;
  localparam logic [1:0] SIM_BITS_M1 = 2'h3;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SIM_PERIOD_NS = 250000;
  localparam int SIM_CYCLES    = SIM_PERIOD_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic       fas_err;
    logic       code_viol;
    logic       bit_strobe;
    logic       submf_end;
    logic       submf_crc_err;
    logic       submf_idx;
    logic       word_valid;
    logic       word_is_fas;
    logic [3:0] frame_num;
    logic [7:0] word;
    logic       mf_start;
    logic       frame15;
    logic       ts16_valid;
    logic [7:0] ts16_byte;
  } erc_rx_evt_t;

  typedef struct packed {
    logic clear_latches_control;
    logic alarm_sim;
    logic crc_mode;
    logic doubleframe_spare_select;
    logic optical_input_select;
    logic submultiframe_indication_enable;
    logic code_violation_extension_enable;
    logic crc_count_extension_enable;
    logic signaling_stack_enable;
    logic parity_clear_command;
    logic tx_parity_input_enable;
    logic auto_status_transmit;
    logic ts0_transparent_a;
    logic ts0_transparent_b;
  } erc_cfg_t;
endpackage : erc_pkg

// ==== erc_status_counters.sv ====
// Summary of operation
// - framing errors count when in sync, saturating at top
// - alarm simulation bumps framing count every 250 us to saturation
// - clear-latches freezes counters; its release zeroes them
// - code violations count on dual-rail only, saturating
// - alarm simulation bumps violation count every four received bits
// - violation extension widens count to 10 bits, top 1023
// - indication mode counts zero Si bits of frames 13 and 15
// - crc count per errored submultiframe, in sync, multiframe mode only
// - simulation bumps crc count per submultiframe; own 10-bit extension
// - international spare bit reads one in crc multiframe mode
// - tx multiframe flag sets at multiframe start, clears on write/frame 15
// - tx stack and Si bits copied to buffers at each multiframe start
// - rx multiframe flag sets at start in sync, clears on read/frame 15
// - request slip flag sets on unfinished stack access; cleared by clear-latches
// - global parity flag sets on any parity error or simulation
// - tx parity flag sets on enabled parity input error or simulation
// - rx Si bits of frames 13/15 updated each multiframe, else zero
// - line error follows both dual-rail inputs active together
// - signaling stack holds two bytes, raises request, read twice
// - indication bits zero on alignment loss or crc error, else one
// - auto status sends indication bits in tx Si of frames 13/15
// - framing and crc counters treat the asynchronous state as not counting
`timescale 1ns/100ps
`default_nettype none
module erc_status_counters
  import erc_pkg::*;
#(
  parameter int SIM_TICK_CYCLES = SIM_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  addr,
  input  wire logic        read_n,
  input  wire logic        write_n,
  input  wire logic        chip_select_n,
  input  wire logic        dma_acknowledge_n,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata,
  input  wire erc_rx_evt_t rx_evt,
  input  wire erc_cfg_t    cfg,
  input  wire logic        rx_in_sync,
  input  wire logic        rx_mf_sync,
  input  wire logic        tx_mf_start,
  input  wire logic        tx_frame15,
  input  wire logic        tx_si13_wr,
  input  wire logic        tx_si15_wr,
  input  wire logic        tx_stack_slip,
  input  wire logic        parity_error_any,
  input  wire logic        tx_parity_input,
  input  wire logic        line_in_positive,
  input  wire logic        line_in_negative,
  output logic             rx_transfer_request,
  output logic             rx_line_error,
  output logic      [7:0]  tx_sn_buffer,
  output logic             tx_si13,
  output logic             tx_si15
);

  function automatic logic [9:0] sat_inc(input logic [9:0] v, input logic wide);
    logic [9:0] top;
    top = wide ? MAX_WIDE : MAX_NARROW;
    sat_inc = (v >= top) ? v : v + 10'h001;
  endfunction : sat_inc

  logic        crc_mf;
  logic        clr_d;
  logic        clr_fall;
  logic        rd_now;
  logic        rd_d;
  logic        rd_edge;
  logic        wr_now;
  logic        wr_d;
  logic        tx_stack_wr;
  logic        sig_read;
  logic [9:0]  cnt [3];
  logic [2:0]  inc;
  logic [2:0]  wide;
  logic [12:0] sim_tick_cnt;
  logic        sim_tick;
  logic [1:0]  sim_bits;
  logic        tx_flag;
  logic        rx_flag;
  logic        slip_flag;
  logic        global_parity_error;
  logic        tx_parity_error;
  logic        rsif;
  logic        rx_si_frame13;
  logic        rx_si_frame15;
  logic        rx_si_frame13_pend;
  logic        rx_si_frame15_pend;
  logic        si1;
  logic        si2;
  logic        err1;
  logic        err2;
  logic [7:0]  service_word;
  logic [7:0]  sig_stack [2];
  logic        sig_fill;
  logic        sig_full;
  logic [1:0]  sig_reads;
  logic [7:0]  tx_sn_shadow;
  logic        tx_si13_buf;
  logic        tx_si15_buf;
  logic [7:0]  next_rdata;
  logic [7:0]  ext_reg;

  assign crc_mf = cfg.crc_mode & ~cfg.doubleframe_spare_select;
  assign clr_fall = clr_d & ~cfg.clear_latches_control;
  assign rd_now = ~read_n & (~chip_select_n | ~dma_acknowledge_n);
  assign rd_edge = rd_now & ~rd_d;
  assign wr_now = ~write_n & ~chip_select_n;
  // a write access to the tx spare stack address counts once per access
  assign tx_stack_wr = wr_now & ~wr_d & (addr == ADDR_RXSNSTK);
  // dma acknowledge reaches the stack without chip select
  assign sig_read = rd_edge & (~dma_acknowledge_n |
                    (~chip_select_n & addr == ADDR_SIGSTACK));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      clr_d <= 1'b0;
      rd_d  <= 1'b0;
      wr_d  <= 1'b0;
    end else begin
      clr_d <= cfg.clear_latches_control;
      rd_d  <= rd_now;
      wr_d  <= wr_now;
    end
  end

  // simulation time base; a parameter so tests can shorten 250 us
  always_ff @(posedge core_clk) begin
    if (rst || !cfg.alarm_sim) begin
      sim_tick_cnt <= 13'h0000;
    end else if (sim_tick) begin
      sim_tick_cnt <= 13'h0000;
    end else begin
      sim_tick_cnt <= sim_tick_cnt + 13'h0001;
    end
  end
  assign sim_tick = cfg.alarm_sim &&
                    (sim_tick_cnt == 13'(SIM_TICK_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (rst || !cfg.alarm_sim) begin
      sim_bits <= 2'h0;
    end else if (rx_evt.bit_strobe) begin
      sim_bits <= sim_bits + 2'h1;
    end
  end

  always_comb begin
    inc[0] = cfg.alarm_sim ? sim_tick
                           : (rx_evt.fas_err & rx_in_sync);
    if (cfg.alarm_sim) begin
      inc[1] = rx_evt.bit_strobe & (sim_bits == SIM_BITS_M1);
    end else if (cfg.submultiframe_indication_enable) begin
      inc[1] = crc_mf & rx_evt.word_valid & ~rx_evt.word_is_fas &
               ~rx_evt.word[7] & (rx_evt.frame_num == FRAME_13 ||
               rx_evt.frame_num == FRAME_15);
    end else begin
      inc[1] = rx_evt.code_viol & ~cfg.optical_input_select;
    end
    inc[2] = crc_mf & rx_evt.submf_end &
             (cfg.alarm_sim | (rx_evt.submf_crc_err & rx_in_sync));
  end
  assign wide = {cfg.crc_count_extension_enable,
                 cfg.code_violation_extension_enable, 1'b0};

  // freeze while clear-latches is held, zero on its release
  for (genvar i = 0; i < 3; i++) begin : g_cnt
    always_ff @(posedge core_clk) begin
      if (rst || clr_fall) begin
        cnt[i] <= CNT_RESET;
      end else if (!cfg.clear_latches_control && inc[i]) begin
        cnt[i] <= sat_inc(cnt[i], wide[i]);
      end
    end
  end

  // tx multiframe flag and buffers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_flag <= 1'b0;
    end else if (cfg.crc_mode && tx_mf_start) begin
      tx_flag <= 1'b1;
    end else if (tx_stack_wr || (crc_mf && tx_frame15)) begin
      tx_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_sn_shadow <= REG_RESET;
    end else if (tx_stack_wr) begin
      tx_sn_shadow <= wdata;
    end
  end

  // unrewritten data is simply sent again from the buffers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_sn_buffer <= REG_RESET;
      tx_si13_buf  <= 1'b0;
      tx_si15_buf  <= 1'b0;
    end else if (tx_mf_start) begin
      tx_sn_buffer <= tx_sn_shadow;
      tx_si13_buf  <= tx_si13_wr;
      tx_si15_buf  <= tx_si15_wr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_si13 <= 1'b0;
      tx_si15 <= 1'b0;
    end else if (cfg.auto_status_transmit && !cfg.ts0_transparent_a &&
                 !cfg.ts0_transparent_b) begin
      tx_si13 <= si1;
      tx_si15 <= si2;
    end else begin
      tx_si13 <= tx_si13_buf;
      tx_si15 <= tx_si15_buf;
    end
  end

  // rx multiframe flag: the host must poll it within 2 ms
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_flag <= 1'b0;
    end else if (cfg.crc_mode && rx_mf_sync && rx_evt.mf_start) begin
      rx_flag <= 1'b1;
    end else if ((rd_edge && !chip_select_n && addr == ADDR_RXSNSTK) ||
                 (crc_mf && rx_evt.frame15)) begin
      rx_flag <= 1'b0;
    end
  end

  // rx Si capture; first bit of the service word is the msb
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_si_frame13_pend <= 1'b0;
      rx_si_frame15_pend <= 1'b0;
    end else if (rx_evt.word_valid && !rx_evt.word_is_fas) begin
      if (rx_evt.frame_num == FRAME_13) begin
        rx_si_frame13_pend <= rx_evt.word[7];
      end
      if (rx_evt.frame_num == FRAME_15) begin
        rx_si_frame15_pend <= rx_evt.word[7];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !crc_mf) begin
      rx_si_frame13 <= 1'b0;
      rx_si_frame15 <= 1'b0;
    end else if (rx_evt.mf_start) begin
      rx_si_frame13 <= rx_si_frame13_pend;
      rx_si_frame15 <= rx_si_frame15_pend;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      service_word <= REG_RESET;
      rsif         <= 1'b1;
    end else if (rx_evt.word_valid) begin
      if (rx_evt.word_is_fas) begin
        rsif <= rx_evt.word[7];
      end else begin
        service_word <= rx_evt.word;
      end
    end
  end

  // submultiframe crc errors gathered over one multiframe
  always_ff @(posedge core_clk) begin
    if (rst || rx_evt.mf_start) begin
      err1 <= 1'b0;
      err2 <= 1'b0;
    end else if (rx_evt.submf_end && rx_evt.submf_crc_err) begin
      if (rx_evt.submf_idx) begin
        err2 <= 1'b1;
      end else begin
        err1 <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !crc_mf) begin
      si1 <= 1'b1;
      si2 <= 1'b1;
    end else if (!rx_mf_sync) begin
      si1 <= 1'b0;
      si2 <= 1'b0;
    end else if (rx_evt.mf_start) begin
      si1 <= ~err1;
      si2 <= ~err2;
    end
  end

  // parity flags: hardware set wins over the clearing command
  always_ff @(posedge core_clk) begin
    if (rst) begin
      global_parity_error <= 1'b0;
    end else if (parity_error_any || cfg.alarm_sim) begin
      global_parity_error <= 1'b1;
    end else if (cfg.parity_clear_command) begin
      global_parity_error <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_parity_error <= 1'b0;
    end else if ((cfg.tx_parity_input_enable && tx_parity_input) ||
                 cfg.alarm_sim) begin
      tx_parity_error <= 1'b1;
    end else if (clr_fall) begin
      tx_parity_error <= 1'b0;
    end
  end

  // two-byte rx signaling stack
  always_ff @(posedge core_clk) begin
    if (rst || !cfg.signaling_stack_enable) begin
      sig_fill  <= 1'b0;
      sig_full  <= 1'b0;
      sig_reads <= 2'h0;
    end else if (rx_evt.ts16_valid) begin
      sig_stack[sig_fill] <= rx_evt.ts16_byte;
      sig_fill <= ~sig_fill;
      if (sig_fill) begin
        sig_full  <= 1'b1;
        sig_reads <= 2'h0;
      end
    end else if (sig_read && sig_full) begin
      sig_reads <= sig_reads + 2'h1;
      if (sig_reads == 2'h1) begin
        sig_full <= 1'b0;
      end
    end
  end
  assign rx_transfer_request = sig_full;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      slip_flag <= 1'b0;
    end else if (cfg.signaling_stack_enable && ((rx_evt.ts16_valid &&
                 sig_fill && sig_full) || tx_stack_slip)) begin
      slip_flag <= 1'b1;
    end else if (clr_fall) begin
      slip_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_line_error <= 1'b0;
    end else begin
      rx_line_error <= ~cfg.optical_input_select &
                       line_in_positive & line_in_negative;
    end
  end

  always_comb begin
    ext_reg = EXT_ONES;
    if (cfg.code_violation_extension_enable) begin
      ext_reg[EXT_CV8 +: 2] = cnt[1][9:8];
    end
    if (cfg.crc_count_extension_enable) begin
      ext_reg[EXT_CE8 +: 2] = cnt[2][9:8];
    end
  end

  always_comb begin
    next_rdata = REG_RESET;
    if (!dma_acknowledge_n) begin
      next_rdata = sig_stack[sig_reads[0]];
    end else begin
      unique case (addr)
        ADDR_FRAMING:  next_rdata = cnt[0][7:0];
        ADDR_CODEVIOL: next_rdata = cnt[1][7:0];
        ADDR_CRCERR:   next_rdata = cnt[2][7:0];
        ADDR_SERVICE:  next_rdata = {crc_mf | service_word[7],
                                     service_word[6:0]};
        ADDR_SPARE: begin
          next_rdata[SP_TXFLG] = tx_flag;
          next_rdata[SP_RXFLG] = rx_flag;
          next_rdata[SP_SLIP]  = slip_flag;
          next_rdata[SP_GPE]   = global_parity_error;
          next_rdata[SP_XPE]   = tx_parity_error;
          next_rdata[SP_RSIF]  = crc_mf | rsif;
          next_rdata[SP_RX_SI_FRAME13]  = rx_si_frame13;
          next_rdata[SP_RX_SI_FRAME15]  = rx_si_frame15;
        end
        ADDR_SUBMF: begin
          next_rdata[SE_SI1] = si1;
          next_rdata[SE_SI2] = si2;
          next_rdata[SE_ERL] = rx_line_error;
        end
        ADDR_SIGSTACK: next_rdata = sig_stack[sig_reads[0]];
        ADDR_EXTEND:   next_rdata = ext_reg;
        default:       next_rdata = REG_RESET;
      endcase
    end
  end

  // data held until the next read access starts
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata <= REG_RESET;
    end else if (rd_edge) begin
      rdata <= next_rdata;
    end
  end

  a_fec_no_wrap: assert property (@(posedge core_clk) disable iff (rst)
    $past(cnt[0]) == MAX_NARROW && !$past(clr_fall) |-> cnt[0] == MAX_NARROW)
    else $error("framing count wrapped");
  a_fec_async_hold: assert property (@(posedge core_clk) disable iff (rst)
    !rx_in_sync && !cfg.alarm_sim && !clr_fall |=> $stable(cnt[0]))
    else $error("framing count moved out of sync");
  a_clr_zeroes: assert property (@(posedge core_clk) disable iff (rst)
    clr_d && !cfg.clear_latches_control |=> cnt[0] == CNT_RESET &&
    cnt[1] == CNT_RESET && cnt[2] == CNT_RESET)
    else $error("counters not zeroed on release");
  a_clr_freezes: assert property (@(posedge core_clk) disable iff (rst)
    cfg.clear_latches_control && clr_d |=> $stable(cnt[1]))
    else $error("counter moved while frozen");
  a_cv_optical: assert property (@(posedge core_clk) disable iff (rst)
    cfg.optical_input_select && !cfg.submultiframe_indication_enable &&
    !cfg.alarm_sim && !clr_fall |=> $stable(cnt[1]))
    else $error("violation count moved in optical mode");
  a_cv_narrow: assert property (@(posedge core_clk) disable iff (rst)
    !cfg.code_violation_extension_enable && cnt[1] <= MAX_NARROW
    |=> cnt[1] <= MAX_NARROW)
    else $error("violation count passed 255");
  a_gpe_sticky: assert property (@(posedge core_clk) disable iff (rst)
    global_parity_error && !cfg.parity_clear_command |=> global_parity_error)
    else $error("parity flag dropped without command");
  a_gpe_sets: assert property (@(posedge core_clk) disable iff (rst)
    parity_error_any |=> global_parity_error)
    else $error("parity flag not set");
  a_line_error: assert property (@(posedge core_clk) disable iff (rst)
    !cfg.optical_input_select && line_in_positive && line_in_negative
    |=> rx_line_error)
    else $error("line error not raised");
  a_rs_zero: assert property (@(posedge core_clk) disable iff (rst)
    !crc_mf |=> !rx_si_frame13 && !rx_si_frame15)
    else $error("rx Si bits not zero outside multiframe");
  a_si_double: assert property (@(posedge core_clk) disable iff (rst)
    !crc_mf |=> si1 && si2)
    else $error("indication bits not one in doubleframe");
  a_txflag_set: assert property (@(posedge core_clk) disable iff (rst)
    cfg.crc_mode && tx_mf_start |=> tx_flag)
    else $error("tx multiframe flag not set");
  a_ext_ones: assert property (@(posedge core_clk) disable iff (rst)
    (ext_reg & EXT_ONES) == EXT_ONES)
    else $error("unused extension bits not one");

endmodule : erc_status_counters
`default_nettype wire
